// *** fault_monitor_aggregator.sv ***
// fault monitors, sticky flags, masking and combined status
`timescale 1ns/10ps
module fault_monitor_aggregator #(
  parameter int SEC_BITS = 32,
  parameter int MEM_WORDS = 8,
  parameter int MEM_W = 16,
  parameter int GPIOS = 9
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // clock sources: clock levels from main clock and diag oscillator, rising edges detected inside
  input wire logic mclk_tick_i,
  input wire logic diag_oscillator_tick_i,
  input wire logic [7:0] clock_deviation_threshold_i,
  input wire logic [7:0] mclk_wd_threshold_i,
  input wire logic [7:0] diag_oscillator_wd_threshold_i,
  input wire logic mclk_mon_enable_i,
  input wire logic mclk_wd_enable_i,
  input wire logic diag_oscillator_wd_enable_i,
  // adc overrange
  input wire logic [fault_pkg::ADCS-1:0] adc_enable_i,
  input wire logic [fault_pkg::ADCS-1:0] adc_overrange_i,
  input wire logic [fault_pkg::ADCS-1:0] adc_or_enable_i,
  // register section crc
  input wire logic [fault_pkg::SECTIONS-1:0] section_crc_enable_i,
  input wire logic [fault_pkg::SECTIONS*SEC_BITS-1:0] section_bits_i,
  input wire logic [fault_pkg::SECTIONS*16-1:0] section_crc_expected_i,
  input wire logic crc_type_ansi_i,
  // memory map crc
  input wire logic [MEM_WORDS*MEM_W-1:0] memory_words_i,
  input wire logic [15:0] memory_crc_stored_i,
  // gpio readback
  input wire logic [GPIOS-1:0] gpio_output_mode_i,
  input wire logic [GPIOS-1:0] gpio_pin_i,
  // register access monitor
  input wire logic access_valid_i,
  input wire logic [8:0] access_addr_i,
  input wire logic access_implemented_i,
  input wire logic [15:0] access_rdata_i,
  // masks and clears (write-one-to-clear pulses)
  input wire logic [fault_pkg::ADC_ST_W-1:0] adc_fault_mask_i,
  input wire logic [fault_pkg::DIG_ST_W-1:0] digital_fault_mask_i,
  input wire logic [fault_pkg::ADC_ST_W-1:0] adc_status_clear_i,
  input wire logic [fault_pkg::DIG_ST_W-1:0] digital_status_clear_i,
  input wire logic adc_combined_clear_i,
  input wire logic digital_combined_clear_i,
  input wire logic access_fault_clear_i,
  input wire logic supply_combined_fault_i,
  input wire logic frame_start_i,
  // status outputs: flags active low, plus gpio readback fields and read echo
  output logic [fault_pkg::ADC_ST_W-1:0] adc_status_o,
  output logic [fault_pkg::DIG_ST_W-1:0] digital_status_o,
  output logic adc_combined_fault_o,
  output logic digital_combined_fault_o,
  output logic access_fault_o,
  output logic [2*GPIOS-1:0] gpio_readback_field_o,
  output logic [7:0] read_addr_echo_o,
  output logic [15:0] read_data_o,
  output logic [fault_pkg::ST_W-1:0] status_word_o
);
  localparam int BIT_IW = $clog2(SEC_BITS);
  localparam int WORD_IW = $clog2(MEM_WORDS);
  localparam int MEM_BW = $clog2(MEM_W);

  // -----------------------------------------------------------------
  // input synchronisers for asynchronous pins and sources
  // -----------------------------------------------------------------
  logic [1:0] mclk_sync;
  logic [1:0] diag_oscillator_sync;
  logic [GPIOS-1:0] gpio_s1;
  logic [GPIOS-1:0] gpio_s2;
  logic [fault_pkg::ADCS-1:0] or_s1;
  logic [fault_pkg::ADCS-1:0] or_s2;
  logic mclk_prev;
  logic diag_oscillator_prev;
  // two flops each, edge detect only on the second
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mclk_sync <= 2'h0;
      diag_oscillator_sync <= 2'h0;
      mclk_prev <= 1'b0;
      diag_oscillator_prev <= 1'b0;
      gpio_s1 <= '0;
      gpio_s2 <= '0;
      or_s1 <= '0;
      or_s2 <= '0;
    end else begin
      mclk_sync <= {mclk_sync[0], mclk_tick_i};
      diag_oscillator_sync <= {diag_oscillator_sync[0], diag_oscillator_tick_i};
      mclk_prev <= mclk_sync[1];
      diag_oscillator_prev <= diag_oscillator_sync[1];
      gpio_s1 <= gpio_pin_i;
      gpio_s2 <= gpio_s1;
      or_s1 <= adc_overrange_i;
      or_s2 <= or_s1;
    end
  end
  wire mclk_edge = mclk_sync[1] & ~mclk_prev;
  wire diag_oscillator_step = diag_oscillator_sync[1] & ~diag_oscillator_prev;

  // -----------------------------------------------------------------
  // clock monitors: count main edges over a diag window
  // -----------------------------------------------------------------
  logic [fault_pkg::WIN_W-1:0] win_cnt;
  logic [fault_pkg::WIN_W-1:0] mclk_cnt;
  logic [fault_pkg::WIN_W-1:0] gap_cnt;
  wire win_end = diag_oscillator_step && (win_cnt == fault_pkg::WINDOW_LEN - 8'h01);
  wire [fault_pkg::WIN_W-1:0] dev = (mclk_cnt > fault_pkg::WINDOW_LEN) ?
      mclk_cnt - fault_pkg::WINDOW_LEN : fault_pkg::WINDOW_LEN - mclk_cnt;
  wire freq_fault = win_end && (dev > clock_deviation_threshold_i);
  wire mclk_wd_fault = win_end && (mclk_cnt < mclk_wd_threshold_i);
  wire diag_oscillator_wd_fault = (gap_cnt >= diag_oscillator_wd_threshold_i) && (diag_oscillator_wd_threshold_i != 8'h00);
  // window counter, main edge counter, diag gap in main edges
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      win_cnt <= '0;
      mclk_cnt <= '0;
      gap_cnt <= '0;
    end else begin
      if (diag_oscillator_step) begin
        win_cnt <= win_end ? '0 : win_cnt + 8'h01;
      end
      if (win_end) begin
        mclk_cnt <= '0;
      end else if (mclk_edge && mclk_cnt != 8'hFF) begin
        mclk_cnt <= mclk_cnt + 8'h01;
      end
      if (diag_oscillator_step) begin
        gap_cnt <= '0;
      end else if (mclk_edge && gap_cnt != 8'hFF) begin
        gap_cnt <= gap_cnt + 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------
  // register section crc walkers, one bit per diag step
  // -----------------------------------------------------------------
  logic [BIT_IW-1:0] bit_idx;
  wire sec_last = (bit_idx == BIT_IW'(SEC_BITS - 1));
  logic [fault_pkg::SECTIONS-1:0] sec_mismatch;
  // shared bit index walks msb of first register to lsb of last
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bit_idx <= '0;
    end else if (diag_oscillator_step) begin
      bit_idx <= sec_last ? '0 : bit_idx + 1'b1;
    end
  end
  genvar s;
  generate
    for (s = 0; s < fault_pkg::SECTIONS; s++) begin : g_sec
      crc_if ci();
      wire [SEC_BITS-1:0] bits = section_bits_i[s*SEC_BITS +: SEC_BITS];
      wire [15:0] expect_v = section_crc_expected_i[s*16 +: 16];
      assign ci.step = diag_oscillator_step;
      assign ci.start = (bit_idx == '0);
      assign ci.bit_in = bits[BIT_IW'(SEC_BITS - 1) - bit_idx];
      assign ci.poly_ansi = crc_type_ansi_i;
      crc_serial u_crc (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .c(ci)
      );
      // compare at end of pass, only while the section is enabled
      wire [15:0] result = {ci.crc[14:0], 1'b0} ^
          ((ci.crc[15] ^ ci.bit_in) ? (crc_type_ansi_i ? fault_pkg::POLY_ANSI :
          fault_pkg::POLY_CCITT) : 16'h0000);
      assign sec_mismatch[s] = section_crc_enable_i[s] && diag_oscillator_step && sec_last &&
          (result != expect_v);
    end
  endgenerate

  // -----------------------------------------------------------------
  // memory map crc, one word per diag step, always on
  // -----------------------------------------------------------------
  logic [WORD_IW-1:0] word_idx;
  logic [15:0] mem_crc;
  wire word_last = (word_idx == WORD_IW'(MEM_WORDS - 1));
  wire [MEM_W-1:0] cur_word = memory_words_i[word_idx*MEM_W +: MEM_W];
  wire [15:0] mem_base = (word_idx == '0) ? fault_pkg::CRC_SEED : mem_crc;
  wire [15:0] mem_poly = crc_type_ansi_i ? fault_pkg::POLY_ANSI : fault_pkg::POLY_CCITT;
  logic [15:0] next_mem_crc;
  // fold a whole word msb first in one step
  always_comb begin
    next_mem_crc = mem_base;
    for (int i = MEM_W - 1; i >= 0; i--) begin
      next_mem_crc = (next_mem_crc[15] ^ cur_word[i]) ?
          ({next_mem_crc[14:0], 1'b0} ^ mem_poly) : {next_mem_crc[14:0], 1'b0};
    end
  end
  wire mem_mismatch = diag_oscillator_step && word_last && (next_mem_crc != memory_crc_stored_i);
  // word index and running crc
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      word_idx <= '0;
      mem_crc <= fault_pkg::CRC_SEED;
    end else if (diag_oscillator_step) begin
      word_idx <= word_last ? '0 : word_idx + 1'b1;
      mem_crc <= next_mem_crc;
    end
  end

  // -----------------------------------------------------------------
  // sticky detailed flags, set wins over clear
  // -----------------------------------------------------------------
  logic [fault_pkg::ADC_ST_W-1:0] adc_set;
  logic [fault_pkg::DIG_ST_W-1:0] dig_set;
  logic [fault_pkg::ADC_ST_W-1:0] adc_en;
  logic [fault_pkg::ADC_ST_W-1:0] adc_flag;
  logic [fault_pkg::DIG_ST_W-1:0] dig_flag;
  assign adc_set = {diag_oscillator_wd_fault, mclk_wd_fault, freq_fault, or_s2 & adc_enable_i};
  assign adc_en = {diag_oscillator_wd_enable_i, mclk_wd_enable_i, mclk_mon_enable_i, adc_or_enable_i};
  assign dig_set = {mem_mismatch, sec_mismatch};
  wire [fault_pkg::ADC_ST_W-1:0] adc_hit = adc_set & adc_en;
  wire [fault_pkg::ADC_ST_W-1:0] next_adc_flag =
      (adc_flag & ~adc_status_clear_i & adc_en) | adc_hit;
  wire [fault_pkg::DIG_ST_W-1:0] dig_en = {1'b1, section_crc_enable_i};
  wire [fault_pkg::DIG_ST_W-1:0] next_dig_flag =
      (dig_flag & ~digital_status_clear_i & dig_en) | dig_set;
  // internal flags are active high faults
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      adc_flag <= '0;
      dig_flag <= '0;
    end else begin
      adc_flag <= next_adc_flag;
      dig_flag <= next_dig_flag;
    end
  end

  // -----------------------------------------------------------------
  // combined flags with masking and ordered clear
  // -----------------------------------------------------------------
  logic adc_comb;
  logic dig_comb;
  wire adc_raise = |(next_adc_flag & ~adc_fault_mask_i);
  wire dig_raise = |(next_dig_flag & ~digital_fault_mask_i);
  wire adc_may_clear = adc_combined_clear_i && (adc_flag == '0);
  wire dig_may_clear = digital_combined_clear_i && (dig_flag == '0);
  // combined stays sticky; a clear is honoured only once detail is clean
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      adc_comb <= 1'b0;
      dig_comb <= 1'b0;
    end else begin
      adc_comb <= adc_raise | (adc_comb & ~adc_may_clear);
      dig_comb <= dig_raise | (dig_comb & ~dig_may_clear);
    end
  end

  // -----------------------------------------------------------------
  // register access monitor and read echo
  // -----------------------------------------------------------------
  logic acc_flag;
  wire acc_hit = access_valid_i && (access_addr_i >= {1'b0, fault_pkg::ADDR_LIMIT});
  wire acc_real = access_valid_i && access_implemented_i && !acc_hit;
  // sticky access fault plus zeroed echo for unimplemented addresses
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      acc_flag <= 1'b0;
      read_addr_echo_o <= 8'h00;
      read_data_o <= 16'h0000;
    end else begin
      acc_flag <= acc_hit | (acc_flag & ~access_fault_clear_i);
      if (access_valid_i) begin
        read_addr_echo_o <= acc_real ? access_addr_i[7:0] : 8'h00;
        read_data_o <= acc_real ? access_rdata_i : 16'h0000;
      end
    end
  end

  // -----------------------------------------------------------------
  // gpio readback fields
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < GPIOS; g++) begin : g_gpio
      // receiver level reported only for output-mode pins
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          gpio_readback_field_o[2*g +: 2] <= fault_pkg::GPIO_OFF;
        end else begin
          gpio_readback_field_o[2*g +: 2] <= !gpio_output_mode_i[g] ? fault_pkg::GPIO_OFF :
              (gpio_s2[g] ? fault_pkg::GPIO_HIGH : fault_pkg::GPIO_LOW);
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // outputs: active-low flags and frame status word
  // -----------------------------------------------------------------
  logic [fault_pkg::ST_W-1:0] next_status;
  always_comb begin
    next_status = '1;
    next_status[fault_pkg::ST_ACCESS] = ~acc_flag;
    next_status[fault_pkg::ST_DIGITAL] = ~dig_comb;
    next_status[fault_pkg::ST_ADC] = ~adc_comb;
    next_status[fault_pkg::ST_SUPPLY] = supply_combined_fault_i;
  end
  // status word captured at the start of every frame
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      adc_status_o <= '1;
      digital_status_o <= '1;
      adc_combined_fault_o <= 1'b1;
      digital_combined_fault_o <= 1'b1;
      access_fault_o <= 1'b1;
      status_word_o <= '1;
    end else begin
      adc_status_o <= ~adc_flag;
      digital_status_o <= ~dig_flag;
      adc_combined_fault_o <= ~adc_comb;
      digital_combined_fault_o <= ~dig_comb;
      access_fault_o <= ~acc_flag;
      if (frame_start_i) begin
        status_word_o <= next_status;
      end
    end
  end
endmodule

// *** fault_pkg.sv ***
// constants and status layouts for the fault monitor aggregator
package fault_pkg;
  localparam int CRC_W = 16;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI = 16'h8005;
  localparam int SECTIONS = 3;
  localparam int ADCS = 3;
  localparam logic [7:0] ADDR_LIMIT = 8'hFF;
  localparam int WIN_W = 8;
  localparam logic [7:0] WINDOW_LEN = 8'h40;
  localparam logic [7:0] DEV_TH_DEFAULT = 8'h04;
  localparam logic [7:0] MCLK_WD_DEFAULT = 8'h10;
  localparam logic [7:0] DIAG_OSCILLATOR_WD_DEFAULT = 8'h08;
  localparam logic [1:0] GPIO_LOW = 2'h0;
  localparam logic [1:0] GPIO_HIGH = 2'h1;
  localparam logic [1:0] GPIO_OFF = 2'h2;
  // adc status layout: overrange flags, then clock flags
  localparam int ADC_ST_W = ADCS + 3;
  localparam int IDX_MCLK_FREQ = ADCS;
  localparam int IDX_MCLK_WD = ADCS + 1;
  localparam int IDX_DIAG_OSCILLATOR_WD = ADCS + 2;
  // digital status layout: section flags then memory flag
  localparam int DIG_ST_W = SECTIONS + 1;
  localparam int IDX_MEM = SECTIONS;
  // main status word layout
  localparam int ST_W = 16;
  localparam int ST_ACCESS = 7;
  localparam int ST_DIGITAL = 8;
  localparam int ST_ADC = 9;
  localparam int ST_SUPPLY = 10;
endpackage

// *** crc_if.sv ***
// serial crc engine control and result bundle
`timescale 1ns/10ps
interface crc_if;
  logic step;
  logic start;
  logic bit_in;
  logic poly_ansi;
  logic [15:0] crc;
  modport engine(input step, input start, input bit_in, input poly_ansi, output crc);
  modport user(output step, output start, output bit_in, output poly_ansi, input crc);
endinterface

// *** crc_serial.sv ***
// one-bit-per-step crc-16 engine
`timescale 1ns/10ps
module crc_serial (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control bundle
  crc_if.engine c
);
  logic [15:0] crc;
  logic [15:0] base;
  logic fb;
  logic [15:0] poly;
  logic [15:0] next_crc;
  // seed on start, then shift one bit msb first
  assign base = c.start ? fault_pkg::CRC_SEED : crc;
  assign fb = base[15] ^ c.bit_in;
  assign poly = c.poly_ansi ? fault_pkg::POLY_ANSI : fault_pkg::POLY_CCITT;
  assign next_crc = {base[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
  assign c.crc = crc;
  // register advances only on diag oscillator step
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      crc <= fault_pkg::CRC_SEED;
    end else if (c.step) begin
      crc <= next_crc;
    end
  end
endmodule

// *** fault_monitor_aggregator_asserts.sv ***
// concurrent checks on the fault monitor aggregator ports
`timescale 1ns/10ps
module fault_monitor_aggregator_asserts #(
  parameter int SEC_BITS = 32,
  parameter int MEM_WORDS = 8,
  parameter int MEM_W = 16,
  parameter int GPIOS = 9
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire logic [fault_pkg::ADCS-1:0] adc_enable_i,
  input wire logic [fault_pkg::ADCS-1:0] adc_overrange_i,
  input wire logic [fault_pkg::ADCS-1:0] adc_or_enable_i,
  input wire logic [fault_pkg::SECTIONS-1:0] section_crc_enable_i,
  input wire logic [GPIOS-1:0] gpio_output_mode_i,
  input wire logic [GPIOS-1:0] gpio_pin_i,
  input wire logic access_valid_i,
  input wire logic [8:0] access_addr_i,
  input wire logic access_implemented_i,
  input wire logic [fault_pkg::DIG_ST_W-1:0] digital_fault_mask_i,
  input wire logic [fault_pkg::DIG_ST_W-1:0] digital_status_clear_i,
  input wire logic supply_combined_fault_i,
  input wire logic frame_start_i,
  // watched outputs
  input wire logic [fault_pkg::ADC_ST_W-1:0] adc_status_o,
  input wire logic [fault_pkg::DIG_ST_W-1:0] digital_status_o,
  input wire logic digital_combined_fault_o,
  input wire logic access_fault_o,
  input wire logic [2*GPIOS-1:0] gpio_readback_field_o,
  input wire logic [7:0] read_addr_echo_o,
  input wire logic [15:0] read_data_o,
  input wire logic [fault_pkg::ST_W-1:0] status_word_o
);
  // ----------
  // properties
  // ----------
  // decodes shared by the properties
  wire logic bad_acc = access_valid_i && access_addr_i >= 9'h0FF;
  wire logic dig_hit = |(~digital_status_o & ~digital_fault_mask_i);
  wire logic mem_ok = digital_status_o[fault_pkg::IDX_MEM];
  wire logic mem_clr = digital_status_clear_i[fault_pkg::IDX_MEM];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  a_access_sets: assert property (
    bad_acc |-> ##2 !access_fault_o) else $error("access fault not raised");
  a_access_quiet: assert property (
    access_valid_i && !bad_acc && access_fault_o && !$past(bad_acc) |-> ##2 access_fault_o)
    else $error("access fault raised below limit");
  a_unimpl_zero: assert property (
    access_valid_i && !access_implemented_i |=> read_addr_echo_o == 8'h00 && read_data_o == 16'h0000)
    else $error("unimplemented read not zero");
  a_mem_sticky: assert property (
    !mem_ok && !mem_clr && !$past(mem_clr) |=> !mem_ok) else $error("memory flag released");
  a_dig_combined: assert property (
    dig_hit && $stable(digital_fault_mask_i) && digital_fault_mask_i == $past(digital_fault_mask_i, 3)
    |-> !digital_combined_fault_o) else $error("combined digital flag missing");
  a_clear_refused: assert property (
    !digital_combined_fault_o && !(&digital_status_o) && digital_status_clear_i == 4'h0
    && $past(digital_status_clear_i) == 4'h0
    && section_crc_enable_i == $past(section_crc_enable_i, 2) |=> !digital_combined_fault_o)
    else $error("combined flag cleared early");
  a_word_supply: assert property (
    frame_start_i && $stable(supply_combined_fault_i)
    |-> ##2 status_word_o[fault_pkg::ST_SUPPLY] == $past(supply_combined_fault_i, 2))
    else $error("status word supply bit wrong");
  a_gpio_read: assert property (
    ($stable(gpio_output_mode_i[0]) && $stable(gpio_pin_i[0]))[*6]
    |-> gpio_readback_field_o[1:0] == (gpio_output_mode_i[0] ? {1'b0, gpio_pin_i[0]} : 2'h2))
    else $error("gpio readback field wrong");
  a_adc_overrange: assert property (
    (adc_enable_i[0] && adc_or_enable_i[0] && adc_overrange_i[0])[*8] |-> !adc_status_o[0])
    else $error("overrange flag not set");
  a_adc_disabled: assert property (
    (!adc_or_enable_i[0])[*6] |-> adc_status_o[0]) else $error("disabled monitor flagged");
  // main scenarios
  c_bad_access: cover property (bad_acc);
  c_dig_fault: cover property (dig_hit && !digital_combined_fault_o);
  c_frame: cover property (frame_start_i);
endmodule
bind fault_monitor_aggregator fault_monitor_aggregator_asserts #(
  .SEC_BITS(SEC_BITS), .MEM_WORDS(MEM_WORDS), .MEM_W(MEM_W), .GPIOS(GPIOS)
) asserts_i (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .adc_enable_i(adc_enable_i),
  .adc_overrange_i(adc_overrange_i), .adc_or_enable_i(adc_or_enable_i),
  .section_crc_enable_i(section_crc_enable_i), .gpio_output_mode_i(gpio_output_mode_i),
  .gpio_pin_i(gpio_pin_i), .access_valid_i(access_valid_i), .access_addr_i(access_addr_i),
  .access_implemented_i(access_implemented_i), .digital_fault_mask_i(digital_fault_mask_i),
  .digital_status_clear_i(digital_status_clear_i), .frame_start_i(frame_start_i),
  .supply_combined_fault_i(supply_combined_fault_i), .adc_status_o(adc_status_o),
  .digital_status_o(digital_status_o), .digital_combined_fault_o(digital_combined_fault_o),
  .access_fault_o(access_fault_o), .gpio_readback_field_o(gpio_readback_field_o),
  .read_addr_echo_o(read_addr_echo_o), .read_data_o(read_data_o), .status_word_o(status_word_o)
);

// *** clock_source_model.sv ***
// clock source model: main clock and diag oscillator levels
`timescale 1ns/10ps
module clock_source_model (
  // clock
  input wire logic core_clk_i,
  // half periods in core cycles, zero stops the level
  input wire logic [7:0] mclk_half_i,
  input wire logic [7:0] diag_half_i,
  // clock levels
  output logic mclk_o,
  output logic diag_o
);
  int mcnt = 0;
  int dcnt = 3;
  // toggle each level after its half period, away from the sampling edge
  always @(negedge core_clk_i) begin
    mcnt = mcnt + 1;
    dcnt = dcnt + 1;
    if (mclk_half_i != 8'h00 && mcnt >= mclk_half_i) begin
      mclk_o <= (mclk_o === 1'b1) ? 1'b0 : 1'b1;
      mcnt = 0;
    end
    if (diag_half_i != 8'h00 && dcnt >= diag_half_i) begin
      diag_o <= (diag_o === 1'b1) ? 1'b0 : 1'b1;
      dcnt = 0;
    end
  end
endmodule

// *** tb_fault_monitor_aggregator.sv ***
// self-checking bench for the fault monitor aggregator
`timescale 1ns/10ps
module tb_fault_monitor_aggregator;
  localparam int SB = 32;
  localparam int MW = 8;
  localparam int GP = 9;
  // stimulus and observed signals
  logic core_clk_i = 1'b0, reset_i = 1'b1, crc_ansi = 1'b0, av = 1'b0, ai = 1'b0;
  logic acclr = 1'b0, dcclr = 1'b0, afclr = 1'b0, fs = 1'b0, sup = 1'b1;
  logic [7:0] mhalf = 8'h04, dhalf = 8'h04;
  logic [2:0] clk_en = 3'h7, adc_en = 3'h7, ovr = 3'h0, or_en = 3'h7, sec_en = 3'h0;
  logic [3*SB-1:0] sec_bits = '0;
  logic [47:0] sec_exp = '0;
  logic [MW*16-1:0] mem = '0;
  logic [15:0] mem_crc = 16'h0000, rd = 16'h0000, rdo, stw, poly;
  logic [GP-1:0] gmode = '0, gpin = '0;
  logic [8:0] aa = 9'h000;
  logic [5:0] amask = 6'h00, aclr = 6'h00, adc_st;
  logic [3:0] dmask = 4'hC, dclr = 4'h0, dig_st;
  logic mclk, diag, acomb, dcomb, afault;
  logic [2*GP-1:0] gfield, ge;
  logic [7:0] echo;
  logic [8:0] at [4] = '{9'h012, 9'h0FE, 9'h0FF, 9'h1FF};
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  bit bq[$];
  // design and clock sources
  fault_monitor_aggregator #(.SEC_BITS(SB), .MEM_WORDS(MW), .MEM_W(16), .GPIOS(GP))
    fault_monitor_aggregator_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .mclk_tick_i(mclk), .diag_oscillator_tick_i(diag),
    .clock_deviation_threshold_i(fault_pkg::DEV_TH_DEFAULT),
    .mclk_wd_threshold_i(fault_pkg::MCLK_WD_DEFAULT),
    .diag_oscillator_wd_threshold_i(fault_pkg::DIAG_OSCILLATOR_WD_DEFAULT), .mclk_mon_enable_i(clk_en[0]),
    .mclk_wd_enable_i(clk_en[1]), .diag_oscillator_wd_enable_i(clk_en[2]), .adc_enable_i(adc_en),
    .adc_overrange_i(ovr), .adc_or_enable_i(or_en), .section_crc_enable_i(sec_en),
    .section_bits_i(sec_bits), .section_crc_expected_i(sec_exp), .crc_type_ansi_i(crc_ansi),
    .memory_words_i(mem), .memory_crc_stored_i(mem_crc), .gpio_output_mode_i(gmode),
    .gpio_pin_i(gpin), .access_valid_i(av), .access_addr_i(aa), .access_implemented_i(ai),
    .access_rdata_i(rd), .adc_fault_mask_i(amask), .digital_fault_mask_i(dmask),
    .adc_status_clear_i(aclr), .digital_status_clear_i(dclr), .adc_combined_clear_i(acclr),
    .digital_combined_clear_i(dcclr), .access_fault_clear_i(afclr),
    .supply_combined_fault_i(sup), .frame_start_i(fs), .adc_status_o(adc_st),
    .digital_status_o(dig_st), .adc_combined_fault_o(acomb), .digital_combined_fault_o(dcomb),
    .access_fault_o(afault), .gpio_readback_field_o(gfield), .read_addr_echo_o(echo),
    .read_data_o(rdo), .status_word_o(stw));
  clock_source_model clock_source_model_i (.core_clk_i(core_clk_i), .mclk_half_i(mhalf),
    .diag_half_i(dhalf), .mclk_o(mclk), .diag_o(diag));
  // ----------
  // helpers
  // ----------
  // clock and hang guard
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // count every check and print each mismatch
  task automatic tally(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic [17:0] got, input logic [17:0] exp);
    tally(got, exp);
  endtask
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    tally({2'b00, got}, {2'b00, exp});
  endtask
  // reference crc: msb first, no reflection, seed all ones
  function automatic logic [15:0] crc_q(input logic [15:0] p);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (bq[k]) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ bq[k]) ? p : 16'h0000);
    end
    return c;
  endfunction
  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  initial begin
    void'($urandom(32'h6B92314D));
    tick(3);
    reset_i = 1'b0;
    tick(2);
    cmp_data(stw, 16'hFFFF);
    cmp_flag({adc_st, dig_st}, 10'h3FF);
    for (int r = 0; r < 2; r++) begin
      gmode = $urandom;
      gpin = $urandom;
      tick(8);
      for (int g = 0; g < GP; g++) begin
        ge[2*g +: 2] = gmode[g] ? {1'b0, gpin[g]} : 2'h2;
      end
      cmp_flag(gfield, ge);
    end
    for (int i = 0; i < 4; i++) begin
      av = 1'b1;
      aa = at[i];
      ai = (i == 0);
      rd = $urandom;
      tick(1);
      av = 1'b0;
      tick(3);
      cmp_flag(afault, at[i] < 9'h0FF);
      cmp_data({echo, 8'h00}, (i == 0) ? 16'h1200 : 16'h0000);
      cmp_data(rdo, (i == 0) ? rd : 16'h0000);
      afclr = 1'b1;
      tick(1);
      afclr = 1'b0;
      tick(3);
    end
    for (int p = 0; p < 2; p++) begin
      sec_en = 3'h0;
      tick(300);
      crc_ansi = p[0];
      poly = p[0] ? 16'h8005 : 16'h1021;
      sec_bits = {$urandom, $urandom, $urandom};
      mem = {$urandom, $urandom, $urandom, $urandom};
      for (int s = 0; s < 3; s++) begin
        bq.delete();
        for (int b = SB - 1; b >= 0; b--) begin
          bq.push_back(sec_bits[s*SB + b]);
        end
        sec_exp[s*16 +: 16] = crc_q(poly) ^ ((s == 2) ? 16'h0001 : 16'h0000);
      end
      bq.delete();
      for (int b = MW*16 - 1; b >= 0; b--) begin
        bq.push_back(mem[(MW - 1 - b/16)*16 + b%16]);
      end
      mem_crc = crc_q(poly);
      tick(300);
      dclr = 4'hF;
      tick(1);
      dclr = 4'h0;
      tick(3);
      sec_en = 3'h7;
      tick(700);
      cmp_flag(dig_st, 4'hB);
      cmp_flag(dcomb, 1'b1);
    end
    sec_en = 3'h3;
    tick(6);
    cmp_flag(dig_st, 4'hF);
    dmask = 4'h0;
    sup = 1'b0;
    mem_crc = mem_crc ^ 16'h0001;
    tick(200);
    cmp_flag({dig_st, dcomb}, 5'h0E);
    fs = 1'b1;
    tick(1);
    fs = 1'b0;
    tick(3);
    cmp_data(stw, 16'hFAFF);
    sup = 1'b1;
    mem_crc = mem_crc ^ 16'h0001;
    tick(200);
    dcclr = 1'b1;
    tick(1);
    dcclr = 1'b0;
    tick(3);
    cmp_flag({dig_st, dcomb}, 5'h0E);
    dclr = 4'h8;
    tick(1);
    dclr = 4'h0;
    tick(3);
    dcclr = 1'b1;
    tick(1);
    dcclr = 1'b0;
    tick(3);
    cmp_flag({dig_st, dcomb}, 5'h1F);
    for (int i = 0; i < 3; i++) begin
      ovr = 3'b001 << i;
      tick(10);
      ovr = 3'h0;
      tick(6);
      cmp_flag(adc_st[2:0], 3'(~(3'b001 << i)));
      aclr = 6'h07;
      tick(1);
      aclr = 6'h00;
      tick(3);
      cmp_flag({adc_st, acomb}, 7'h7E);
    end
    acclr = 1'b1;
    tick(1);
    acclr = 1'b0;
    or_en = 3'h6;
    ovr = 3'h1;
    tick(12);
    cmp_flag({adc_st, acomb}, 7'h7F);
    ovr = 3'h0;
    or_en = 3'h7;
    mhalf = 8'h02;
    tick(1200);
    cmp_flag(adc_st[3], 1'b0);
    mhalf = 8'h00;
    tick(1200);
    cmp_flag(adc_st[4], 1'b0);
    mhalf = 8'h04;
    dhalf = 8'h00;
    tick(200);
    cmp_flag({adc_st[5], acomb}, 2'h0);
    clk_en = 3'h0;
    tick(6);
    cmp_flag(adc_st[5:3], 3'h7);
    final_report();
  end
endmodule
